// file: src/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_CONFIG_WRITE  = 8'h31;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_FAST_READ     = 8'h0B;
  localparam logic [7:0] OP_DUAL_READ     = 8'h3B;
  localparam logic [7:0] OP_BUSY_MONITOR  = 8'h25;

  // ==========================================================================
  // Status bit positions
  localparam int SB_BUSY       = 0;
  localparam int SB_LATCH      = 1;
  localparam int SB_PROT_LO    = 7;
  localparam int SB_PROT_HI    = 8;
  localparam int SB_QUAD_EN    = 9;
  localparam int SB_SUSP2      = 10;
  localparam int SB_PROT_CMPL  = 14;
  localparam int SB_SUSP1      = 15;

  // Reset values of the register images
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0]  CONFIG_RESET = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS       = 8;
  localparam int REG_WRITE_TIME_NS   = 5000000; // Register write time, 5 ms
  localparam int REG_WRITE_CYCLES    = REG_WRITE_TIME_NS / CLK_PERIOD_NS;

  // Bit counts of command phases
  localparam logic [5:0] OPCODE_BITS  = 6'd8;
  localparam logic [5:0] ADDR_END     = 6'd32;
  localparam logic [5:0] DUMMY_END    = 6'd40;
  localparam logic [5:0] DATA_ONE     = 6'd16;
  localparam logic [5:0] DATA_TWO     = 6'd24;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_WDATA, ST_MONITOR, ST_DATA, ST_IGNORE
  } phase_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } link_in_s;

endpackage

// file: src/flash_array_mem.sv
`timescale 1ns/1ps
// ============================================================================
// Array storage with registered read data
module flash_array_mem
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              i_clk,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_we,
  input  wire logic [7:0]        i_wdata,
  output logic      [7:0]        o_rdata
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // Write port for preload; read port registered
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule // flash_array_mem

// file: src/flash_cmd_front.sv
`timescale 1ns/1ps
// Behaviour
// - Input ignored after monitor opcode
// - Monitor drives live busy flag out
// - Chip select release ends monitor, tristates
// - Register writes need write latch set
// - Status write keeps bits 15,10,1,0
// - Status write only at 8/16 bits
// - One-byte status write clears three bits
// - Status write timed cycle, then clears latch
// - Status image on o_status during timed cycle
// - Hardware protected mode refuses status writes
// - Lock when protect bits 01, pin low
// - Config write only at 8 bits
// - Config write starts timed busy cycle
// - Plain read: address rising, data falling
// - Read address increments, wraps to zero
// - Fast read has one dummy byte
// - Fast read rejected while busy
// - Dual read: dummy, two bits per clock
// - Dual read rejected while busy
// - Busy flag is status bit 0
// - Latch zero blocks writes
module flash_cmd_front
  import flash_cmd_pkg::*;
#(
  parameter int MEM_ADDR_W   = 10,
  parameter int WRITE_CYCLES = REG_WRITE_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_io0,
  input  wire logic        i_wp_n,
  input  wire logic        i_ext_busy,
  input  wire logic        i_mem_we,
  input  wire logic [7:0]  i_mem_wdata,
  input  wire logic [9:0]  i_mem_waddr,
  output logic             o_io0,
  output logic             o_io0_oe,
  output logic             o_io1,
  output logic             o_io1_oe,
  output logic [15:0]      o_status,
  output logic [7:0]       o_config,
  output logic             o_reject
);

  // ==========================================================================
  // Pin synchronisers: two flops before any logic
  link_in_s sync1_q;
  link_in_s sync2_q;
  link_in_s prev_q;
  logic     wp_sync1_q;
  logic     wp_sync2_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
      sync2_q <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
      prev_q  <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
      wp_sync1_q <= 1'b1; // Unlocked level until the pin is seen
      wp_sync2_q <= 1'b1;
    end else begin
      sync1_q <= '{sclk: i_sclk, cs_n: i_cs_n, si: i_io0};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      wp_sync1_q <= i_wp_n; // Protect pin is asynchronous as well
      wp_sync2_q <= wp_sync1_q;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic sel;
  assign sclk_rise = sync2_q.sclk & ~prev_q.sclk;
  assign sclk_fall = ~sync2_q.sclk & prev_q.sclk;
  assign cs_fall   = ~sync2_q.cs_n & prev_q.cs_n;
  assign cs_rise   = sync2_q.cs_n & ~prev_q.cs_n;
  assign sel       = ~sync2_q.cs_n;

  // ==========================================================================
  // Command state
  phase_e      phase_q;
  logic [5:0]  bits_q;
  logic [7:0]  opcode_q;
  logic [23:0] shift_q;
  logic [15:0] wdata_q;
  logic [23:0] addr_q;
  logic [7:0]  dout_q;
  logic [2:0]  out_cnt_q;
  logic [15:0] status_q;
  logic [7:0]  config_q;
  logic        timed_q;
  logic [31:0] timer_q;
  logic        busy;
  logic [7:0]  mem_rdata;
  logic [7:0]  op_next;

  assign busy    = timed_q | i_ext_busy;
  assign op_next = {opcode_q[6:0], sync2_q.si};

  // Hardware lock decode, used by status write acceptance
  function automatic logic hw_locked(input logic [15:0] st, input logic wp_n);
    hw_locked = ~st[SB_PROT_HI] & st[SB_PROT_LO] & ~wp_n;
  endfunction

  // Write gating: latch set, not busy
  function automatic logic write_ok(input logic [15:0] st);
    write_ok = st[SB_LATCH] & ~st[SB_BUSY];
  endfunction

  // ==========================================================================
  // Bit sequencer: sampling on rising edges, MSB first
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_q  <= ST_IDLE;
      bits_q   <= 6'd0;
      opcode_q <= 8'h00;
      shift_q  <= 24'h000000;
      wdata_q  <= 16'h0000;
    end else if (!sel) begin
      phase_q <= ST_IDLE;
      bits_q  <= 6'd0;
    end else if (cs_fall) begin
      phase_q <= ST_OPCODE;
      bits_q  <= 6'd0;
    end else if (sclk_rise) begin
      bits_q <= (bits_q == 6'h3F) ? bits_q : bits_q + 6'd1;
      unique case (phase_q)
        ST_OPCODE: begin
          opcode_q <= op_next;
          if (bits_q == OPCODE_BITS - 6'd1) begin
            unique case (op_next)
              OP_BUSY_MONITOR: phase_q <= ST_MONITOR;
              OP_STATUS_WRITE,
              OP_CONFIG_WRITE: phase_q <= ST_WDATA;
              OP_READ:         phase_q <= ST_ADDR;
              OP_FAST_READ,
              OP_DUAL_READ:    phase_q <= busy ? ST_IGNORE : ST_ADDR;
              default:         phase_q <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          if (bits_q < ADDR_END) begin
            shift_q <= {shift_q[22:0], sync2_q.si};
          end
          if ((opcode_q == OP_READ && bits_q == ADDR_END - 6'd1) ||
              bits_q == DUMMY_END - 6'd1) begin
            phase_q <= ST_DATA;
          end
        end
        ST_WDATA: wdata_q <= {wdata_q[14:0], sync2_q.si};
        ST_MONITOR: phase_q <= ST_MONITOR;
        default: phase_q <= phase_q;
      endcase
    end
  end

  // ==========================================================================
  // Read address: load at end of address (plain read) or dummy (fast/dual), step per byte, wrap naturally
  logic data_start;
  assign data_start = sclk_rise && phase_q == ST_ADDR &&
                      (opcode_q == OP_READ ? bits_q == ADDR_END - 6'd1
                                           : bits_q == DUMMY_END - 6'd1);

  logic [23:0] addr_load;
  assign addr_load = (opcode_q == OP_READ) ? {shift_q[22:0], sync2_q.si} : shift_q;

  logic byte_done;
  logic first_q;
  logic dual;
  assign dual      = opcode_q == OP_DUAL_READ;
  // Step as each byte is loaded, so the next one is read well ahead
  assign byte_done = sclk_fall && phase_q == ST_DATA &&
                     (first_q || out_cnt_q == (dual ? 3'd3 : 3'd7));

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_q <= 24'h000000;
    end else if (data_start) begin
      addr_q <= addr_load;
    end else if (byte_done) begin
      addr_q <= addr_q + 24'd1;
    end
  end

  flash_array_mem #(.ADDR_W(MEM_ADDR_W)) u_mem (
    .i_clk   (i_clk),
    .i_addr  (i_mem_we ? i_mem_waddr[MEM_ADDR_W-1:0] : addr_q[MEM_ADDR_W-1:0]),
    .i_we    (i_mem_we),
    .i_wdata (i_mem_wdata),
    .o_rdata (mem_rdata)
  );

  // ==========================================================================
  // Output shifter on falling edges; a fresh byte loads as the last goes out
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dout_q    <= 8'h00;
      out_cnt_q <= 3'd0;
      first_q   <= 1'b0;
    end else if (phase_q != ST_DATA) begin
      out_cnt_q <= 3'd0;
      first_q   <= 1'b1;
    end else if (sclk_fall) begin
      first_q <= 1'b0;
      if (first_q || out_cnt_q == (dual ? 3'd3 : 3'd7)) begin
        dout_q    <= mem_rdata; // Next byte already read after address step
        out_cnt_q <= 3'd0;
      end else begin
        dout_q    <= dual ? {dout_q[5:0], 2'b00} : {dout_q[6:0], 1'b0};
        out_cnt_q <= out_cnt_q + 3'd1;
      end
    end
  end

  // Pin drivers, registered; high impedance by enable only
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_io0    <= 1'b0;
      o_io0_oe <= 1'b0;
      o_io1    <= 1'b0;
      o_io1_oe <= 1'b0;
    end else if (!sel) begin
      o_io0_oe <= 1'b0;
      o_io1_oe <= 1'b0;
    end else if (phase_q == ST_MONITOR) begin
      o_io1    <= busy;
      o_io1_oe <= 1'b1;
    end else if (phase_q == ST_DATA && !first_q) begin
      o_io1    <= dout_q[7];
      o_io1_oe <= 1'b1;
      o_io0    <= dout_q[6];
      o_io0_oe <= dual;
    end
  end

  // ==========================================================================
  // Register write commit on chip select rise
  logic sr_ok;
  logic cr_ok;
  assign sr_ok = cs_rise && phase_q == ST_WDATA && opcode_q == OP_STATUS_WRITE &&
                 (bits_q == DATA_ONE || bits_q == DATA_TWO) &&
                 write_ok(status_q) && !hw_locked(status_q, wp_sync2_q);
  assign cr_ok = cs_rise && phase_q == ST_WDATA && opcode_q == OP_CONFIG_WRITE &&
                 bits_q == DATA_ONE && write_ok(status_q);

  logic write_enable_cmd_ok;
  assign write_enable_cmd_ok = cs_rise && phase_q == ST_IGNORE && opcode_q == OP_WRITE_ENABLE &&
                   bits_q == OPCODE_BITS;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_q <= STATUS_RESET;
      config_q <= CONFIG_RESET;
      timed_q  <= 1'b0;
      timer_q  <= 32'd0;
    end else begin
      status_q[SB_BUSY] <= busy;
      if (sr_ok) begin
        if (bits_q == DATA_ONE) begin
          status_q[7:2]            <= wdata_q[7:2];
          status_q[SB_PROT_CMPL]   <= 1'b0;
          status_q[SB_QUAD_EN]     <= 1'b0;
          status_q[SB_PROT_HI]     <= 1'b0;
        end else begin
          status_q[7:2]  <= wdata_q[15:10];
          status_q[14:11] <= wdata_q[6:3];
          status_q[9:8]  <= wdata_q[1:0];
        end
      end
      if (cr_ok) begin
        config_q <= wdata_q[7:0];
      end
      if (sr_ok || cr_ok) begin
        timed_q <= 1'b1;
        timer_q <= 32'(WRITE_CYCLES);
      end else if (timed_q) begin
        if (timer_q <= 32'd1) begin
          timed_q          <= 1'b0;
          status_q[SB_LATCH] <= 1'b0;
        end
        timer_q <= timer_q - 32'd1;
      end else if (write_enable_cmd_ok) begin
        status_q[SB_LATCH] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status <= STATUS_RESET;
      o_config <= CONFIG_RESET;
      o_reject <= 1'b0;
    end else begin
      o_status <= status_q;
      o_config <= config_q;
      o_reject <= sclk_rise && phase_q == ST_OPCODE && bits_q == OPCODE_BITS - 6'd1 &&
                  (op_next == OP_FAST_READ || op_next == OP_DUAL_READ) && busy;
    end
  end

endmodule // flash_cmd_front

// file: sim/flash_cmd_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checks of the command front end
module flash_cmd_chk
  import flash_cmd_pkg::*;
#(
  parameter int MEM_ADDR_W   = 10,
  parameter int WRITE_CYCLES = 20
) (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_sclk,
  input wire logic        i_cs_n,
  input wire logic        i_io0,
  input wire logic        i_wp_n,
  input wire logic        i_ext_busy,
  input wire logic        i_mem_we,
  input wire logic [7:0]  i_mem_wdata,
  input wire logic [9:0]  i_mem_waddr,
  input wire logic        o_io0,
  input wire logic        o_io0_oe,
  input wire logic        o_io1,
  input wire logic        o_io1_oe,
  input wire logic [15:0] o_status,
  input wire logic [7:0]  o_config,
  input wire logic        o_reject
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Release seen, then settled through the synchroniser
  sequence s_cs_rel;
    $rose(i_cs_n) ##1 i_cs_n [*7];
  endsequence
  // Timed cycle begun by the block itself
  sequence s_busy_up;
    $rose(o_status[SB_BUSY]) && !i_ext_busy;
  endsequence
  AST_OE_DROP: assert property (s_cs_rel |-> !o_io1_oe && !o_io0_oe)
    else $error("output enable held after release");
  AST_BUSY_EXT: assert property (i_ext_busy [*4] |-> o_status[SB_BUSY])
    else $error("busy bit low during outside operation");
  AST_BUSY_RISE: assert property ($rose(o_status[SB_BUSY]) |-> i_cs_n || i_ext_busy)
    else $error("busy rose inside a frame");
  AST_BUSY_HOLD: assert property (s_busy_up |=> o_status[SB_BUSY] [*8])
    else $error("timed cycle too short");
  AST_KEEP: assert property ($stable({o_status[SB_SUSP1], o_status[SB_SUSP2]}))
    else $error("suspend bits changed");
  AST_GATE: assert property ($changed({o_status[15:2], o_config}) |-> $past(o_status[SB_LATCH]))
    else $error("register changed without write latch");
  AST_FRAME: assert property (!i_cs_n [*6] |-> $stable({o_status[15:2], o_config}))
    else $error("register changed before release");
  AST_REJ_BUSY: assert property (o_reject |-> o_status[SB_BUSY] || i_ext_busy)
    else $error("read refused while idle");
  AST_REJ_ONE: assert property (o_reject |=> !o_reject)
    else $error("refusal pulse too long");
endmodule // flash_cmd_chk

bind flash_cmd_front flash_cmd_chk #(.MEM_ADDR_W(MEM_ADDR_W), .WRITE_CYCLES(WRITE_CYCLES))
  u_flash_cmd_chk (.i_clk, .i_arst_n, .i_sclk, .i_cs_n, .i_io0, .i_wp_n, .i_ext_busy,
  .i_mem_we, .i_mem_wdata, .i_mem_waddr, .o_io0, .o_io0_oe, .o_io1, .o_io1_oe,
  .o_status, .o_config, .o_reject);

// file: sim/flash_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Serial host, clock idle low, 16 clk per bit
module flash_host_model (
  input  wire logic i_clk,
  input  wire logic i_so1,
  input  wire logic i_so0,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si
);
  // Idle levels at time zero
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  // Chip select edge with margin for the sampler
  task automatic sel(input logic lvl);
    repeat (8) @(posedge i_clk);
    o_cs_n <= lvl;
    if (lvl) o_si <= ~o_si; // Released line never shows a stale level
    repeat (8) @(posedge i_clk);
  endtask
  // Bits MSB first; lines read just before each rise
  task automatic shift(input int n, input logic [31:0] d,
                       output logic [31:0] q1, output logic [31:0] q0);
    q1 = '0;
    q0 = '0;
    for (int i = n - 1; i >= 0; i--) begin
      o_si <= d[i];
      repeat (8) @(posedge i_clk);
      q1 = {q1[30:0], i_so1};
      q0 = {q0[30:0], i_so0};
      o_sclk <= 1'b1;
      repeat (8) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
  endtask
endmodule // flash_host_model

// file: sim/flash_cmd_front_tb.sv
`timescale 1ns/1ps
module flash_cmd_front_tb;
  import flash_cmd_pkg::*;
  localparam int WC = 300;
  logic        clk, arst_n, wp_n, ext_busy, mem_we;
  logic        sclk, cs_n, si, io0, io1, io0_oe, io1_oe, rej, dq0;
  logic [7:0]  mem_wdata, cfg;
  logic [9:0]  mem_waddr;
  logic [15:0] status;
  logic [31:0] q1, q0;
  int          err_count, n_compared, rej_cnt, r0;
  // ==========================================
  // Clock, wire level and design
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  assign io0 = io0_oe ? dq0 : si;
  flash_cmd_front #(.WRITE_CYCLES(WC)) u_flash_cmd_front (.i_clk(clk), .i_arst_n(arst_n),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_io0(io0), .i_wp_n(wp_n), .i_ext_busy(ext_busy),
    .i_mem_we(mem_we), .i_mem_wdata(mem_wdata), .i_mem_waddr(mem_waddr), .o_io0(dq0),
    .o_io0_oe(io0_oe), .o_io1(io1), .o_io1_oe(io1_oe), .o_status(status),
    .o_config(cfg), .o_reject(rej));
  flash_host_model u_flash_host_model (.i_clk(clk), .i_so1(io1), .i_so0(io0),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));
  // Refusal pulses counted
  always @(posedge clk) if (rej === 1'b1) rej_cnt++;
  // ==========================================
  // Tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Array preload; write enable left up between back-to-back calls
  task automatic preload(input logic [9:0] a, input logic [7:0] d);
    mem_we    <= 1'b1;
    mem_waddr <= a;
    mem_wdata <= d;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [7:0] op, input int n, input logic [31:0] d);
    u_flash_host_model.sel(1'b0);
    u_flash_host_model.shift(8, {24'h0, op}, q1, q0);
    if (n > 0) u_flash_host_model.shift(n, d, q1, q0);
    u_flash_host_model.sel(1'b1);
  endtask
  task automatic rd(input logic [7:0] op, input int dummy, input int n);
    u_flash_host_model.sel(1'b0);
    u_flash_host_model.shift(32, {op, 24'hFFFFFF}, q1, q0);
    if (dummy > 0) u_flash_host_model.shift(dummy, 32'h0, q1, q0);
    u_flash_host_model.shift(n, 32'h0, q1, q0);
    u_flash_host_model.sel(1'b1);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (status[SB_BUSY] !== 1'b0 && k < WC + 50) begin
      @(posedge clk);
      k++;
    end
    if (k >= WC + 50) begin
      err_count++;
      $display("[FAIL] %0t busy stuck", $time);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // Watchdog, about nine times the expected run
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    summarize();
  end
  // ==========================================
  // Tests
  initial begin
    {arst_n, ext_busy, mem_we, mem_wdata, mem_waddr} = '0;
    wp_n = 1'b1;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(status, STATUS_RESET);
    check({cfg, 6'h0, io1_oe, io0_oe}, {CONFIG_RESET, 8'h00});
    preload(10'h3FF, 8'h5A);
    preload(10'h000, 8'hC3);
    mem_we <= 1'b0;
    cmd(OP_STATUS_WRITE, 16, 32'h7C42);
    check(status, 16'h0000);
    cmd(OP_WRITE_ENABLE, 0, 0);
    cmd(OP_STATUS_WRITE, 16, 32'h7FC6);
    check(status, 16'h427F);
    wait_idle();
    check(status, 16'h427C);
    cmd(OP_WRITE_ENABLE, 0, 0);
    cmd(OP_STATUS_WRITE, 12, 32'h0000);
    check(status, 16'h427E);
    cmd(OP_STATUS_WRITE, 8, 32'h80);
    wait_idle();
    check(status, 16'h0080);
    wp_n <= 1'b0;
    cmd(OP_WRITE_ENABLE, 0, 0);
    cmd(OP_STATUS_WRITE, 8, 32'h00);
    check(status, 16'h0082);
    wp_n <= 1'b1;
    cmd(OP_STATUS_WRITE, 8, 32'h00);
    wait_idle();
    check(status, 16'h0000);
    cmd(OP_WRITE_ENABLE, 0, 0);
    cmd(OP_CONFIG_WRITE, 16, 32'hA5A5);
    check({8'h0, cfg}, 16'h0000);
    cmd(OP_CONFIG_WRITE, 8, 32'hA5);
    check({15'h0, status[SB_BUSY]}, 16'h0001);
    wait_idle();
    check({8'h0, cfg}, 16'h00A5);
    rd(OP_READ, 0, 16);
    check(q1[15:0], 16'h5AC3);
    rd(OP_FAST_READ, 8, 8);
    check(q1[15:0], 16'h005A);
    rd(OP_DUAL_READ, 8, 8);
    check({q1[7], q0[7], q1[6], q0[6], q1[5], q0[5], q1[4], q0[4],
           q1[3], q0[3], q1[2], q0[2], q1[1], q0[1], q1[0], q0[0]}, 16'h5AC3);
    ext_busy <= 1'b1;
    r0 = rej_cnt;
    rd(OP_FAST_READ, 8, 8);
    rd(OP_DUAL_READ, 8, 8);
    check(rej_cnt[15:0] - r0[15:0], 16'h0002);
    check(status, 16'h0001);
    u_flash_host_model.sel(1'b0);
    u_flash_host_model.shift(8, {24'h0, OP_BUSY_MONITOR}, q1, q0);
    u_flash_host_model.shift(3, 32'h5, q1, q0);
    check({io1_oe, io1}, 16'h0003);
    ext_busy <= 1'b0;
    repeat (8) @(posedge clk);
    check({io1_oe, io1}, 16'h0002);
    u_flash_host_model.sel(1'b1);
    check({io1_oe, io0_oe}, 16'h0000);
    summarize();
  end
endmodule // flash_cmd_front_tb
